// [logic/dcap_ctrl_port.sv]
/*
 * Debug control access port: soft reset request, erase-all sequencer,
 * protection status, two-way mailbox and erase-guard key unlock.
 * Assumes the debug port holds link_req_i stable around a rising edge of
 * link_clk_i, and that the erase engine answers each stage with done.
 */
// Overview of operation
// - Debugger reset register write requests soft reset and flags it as cause.
// - Erase-all write erases flash, SRAM, user config and peripherals in order.
// - Erase progress reads busy for the whole erase-all sequence.
// - Completed erase releases access guard at the next reset.
// - Subordinate domain erase, when selected at erase start, runs after the application domain stages.
// - Active erase guard after reset refuses debugger erase-all requests.
// - Debugger flash access follows only the access guard, not erase guard.
// - Erase guard blocks debugger erase-all writes and nothing else; matching keys still start erase-all.
// - Access guard blocks the processor access port entirely.
// - Debugger reads secure and non-secure access guard status.
// - Debugger reads erase guard configuration status.
// - Mailbox flags change only by hardware on data writes and reads.
// - Send sets both flags; receive read clears receive flag, then send flag.
// - Debugger send word is read by CPU from its receive word.
// - CPU send word is read by debugger from its receive word.
// - Equal non-zero keys from both sides start a full erase-all.
// - Key-triggered erase re-enables access ports at the following reset.
// - Lock register is set by a write of 1 and then holds; key writes are then ignored until reset.
// - Erase write forces reset request inactive until a system reset.
// - Debugger registers are reachable only over the link.
// - Identification register sits at the top of the debugger space.
`timescale 1ns/1ps
`default_nettype none
module dcap_ctrl_port #(
  parameter logic [31:0] PORT_IDENT = dcap_pkg::PORT_IDENT_DEFAULT
) (
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         link_clk_i,
  input  wire dcap_pkg::dcap_link_req_type  link_req_i,
  output logic [31:0]                       link_rdata_o,
  output logic                              link_ack_o,
  input  wire dcap_pkg::dcap_cpu_req_type   cpu_req_i,
  output logic [31:0]                       cpu_rdata_o,
  output logic                              cpu_ready_o,
  input  wire logic                         access_guard_i,
  input  wire logic                         secure_access_guard_i,
  input  wire logic                         erase_guard_i,
  input  wire logic                         sub_domain_erase_i,
  input  wire logic                         erase_done_i,
  output logic                              erase_req_o,
  output dcap_pkg::dcap_erase_state_type    erase_stage_o,
  output logic                              guard_release_o,
  output logic                              soft_reset_req_o,
  output logic                              reset_cause_soft_o,
  output logic                              processor_ap_enable_o,
  output logic                              dbg_flash_write_allow_o
);

  ////////////////////////////////////////////////////////////////////////
  // Link resampling
  logic                        lclk_meta;
  logic                        lclk_sync;
  logic                        lclk_prev;
  dcap_pkg::dcap_link_req_type lreq_meta;
  dcap_pkg::dcap_link_req_type lreq_sync;
  logic                        link_stb;
  logic                        dbg_wr;
  logic                        dbg_rd;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lclk_meta <= 1'b0;
      lclk_sync <= 1'b0;
      lclk_prev <= 1'b0;
      lreq_meta <= '0;
      lreq_sync <= '0;
    end else begin
      lclk_meta <= link_clk_i;
      lclk_sync <= lclk_meta;
      lclk_prev <= lclk_sync;
      lreq_meta <= link_req_i;
      lreq_sync <= lreq_meta;
    end
  end

  assign link_stb = lclk_sync & ~lclk_prev & lreq_sync.req;
  assign dbg_wr   = link_stb & lreq_sync.wr;
  assign dbg_rd   = link_stb & ~lreq_sync.wr;

  logic cpu_wr;
  logic cpu_rd;
  assign cpu_wr = cpu_req_i.sel & cpu_req_i.wr;
  assign cpu_rd = cpu_req_i.sel & ~cpu_req_i.wr;

  ////////////////////////////////////////////////////////////////////////
  // Configuration taken once after reset release
  logic cfg_taken;
  logic access_guard;
  logic secure_guard;
  logic erase_guard;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_taken    <= 1'b0;
      access_guard <= 1'b1;
      secure_guard <= 1'b1;
      erase_guard  <= 1'b1;
    end else if (!cfg_taken) begin
      cfg_taken    <= 1'b1;
      access_guard <= access_guard_i;
      secure_guard <= secure_access_guard_i;
      erase_guard  <= erase_guard_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      processor_ap_enable_o   <= 1'b0;
      dbg_flash_write_allow_o <= 1'b0;
    end else begin
      processor_ap_enable_o   <= cfg_taken & ~access_guard;
      dbg_flash_write_allow_o <= cfg_taken & ~access_guard;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Erase-guard keys and lock
  logic [31:0] dbg_key;
  logic [31:0] cpu_key;
  logic        key_lock;
  logic        key_match;

  assign key_match = (dbg_key == cpu_key) && (dbg_key != dcap_pkg::WORD_ZERO);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      key_lock <= 1'b0;
    end else if (cpu_wr && cpu_req_i.addr == dcap_pkg::CPU_ERASE_GUARD_LOCK && !key_lock) begin
      key_lock <= cpu_req_i.wdata[dcap_pkg::CTRL_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || key_match) begin
      dbg_key <= dcap_pkg::WORD_ZERO;
      cpu_key <= dcap_pkg::WORD_ZERO;
    end else begin
      if (dbg_wr && lreq_sync.addr == dcap_pkg::DBG_ERASE_GUARD_KEY && !key_lock) begin
        dbg_key <= lreq_sync.wdata;
      end
      if (cpu_wr && cpu_req_i.addr == dcap_pkg::CPU_ERASE_GUARD_KEY && !key_lock) begin
        cpu_key <= cpu_req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Erase-all sequencer
  dcap_pkg::dcap_erase_state_type state;
  dcap_pkg::dcap_erase_state_type next_state;
  logic                           erase_write;
  logic                           erase_start;
  logic                           sub_pending;

  assign erase_write = dbg_wr && lreq_sync.addr == dcap_pkg::DBG_ERASE_ALL_TRIGGER
                       && lreq_sync.wdata[dcap_pkg::CTRL_BIT];
  assign erase_start = (erase_write && cfg_taken && !erase_guard) || key_match;

  always_comb begin
    next_state = state;
    case (state)
      dcap_pkg::DCAP_ES_IDLE: begin
        if (erase_start) begin
          next_state = dcap_pkg::DCAP_ES_FLASH;
        end
      end
      dcap_pkg::DCAP_ES_FLASH: begin
        if (erase_done_i) begin
          next_state = dcap_pkg::DCAP_ES_SRAM;
        end
      end
      dcap_pkg::DCAP_ES_SRAM: begin
        if (erase_done_i) begin
          next_state = dcap_pkg::DCAP_ES_USER_CFG;
        end
      end
      dcap_pkg::DCAP_ES_USER_CFG: begin
        if (erase_done_i) begin
          next_state = dcap_pkg::DCAP_ES_PERIPH;
        end
      end
      dcap_pkg::DCAP_ES_PERIPH: begin
        if (erase_done_i) begin
          next_state = sub_pending ? dcap_pkg::DCAP_ES_SUB_DOMAIN : dcap_pkg::DCAP_ES_DONE;
        end
      end
      dcap_pkg::DCAP_ES_SUB_DOMAIN: begin
        if (erase_done_i) begin
          next_state = dcap_pkg::DCAP_ES_DONE;
        end
      end
      // Done holds until reset so a second erase needs a fresh session
      dcap_pkg::DCAP_ES_DONE: begin
        next_state = dcap_pkg::DCAP_ES_DONE;
      end
      default: begin
        next_state = dcap_pkg::DCAP_ES_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state         <= dcap_pkg::DCAP_ES_IDLE;
      erase_stage_o <= dcap_pkg::DCAP_ES_IDLE;
      erase_req_o   <= 1'b0;
      sub_pending   <= 1'b0;
    end else begin
      state         <= next_state;
      erase_stage_o <= next_state;
      erase_req_o   <= next_state != dcap_pkg::DCAP_ES_IDLE && next_state != dcap_pkg::DCAP_ES_DONE;
      if (state == dcap_pkg::DCAP_ES_IDLE && erase_start) begin
        sub_pending <= sub_domain_erase_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      guard_release_o <= 1'b0;
    end else if (state == dcap_pkg::DCAP_ES_DONE) begin
      guard_release_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Soft reset request
  logic reset_blocked;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      soft_reset_req_o   <= 1'b0;
      reset_cause_soft_o <= 1'b0;
      reset_blocked      <= 1'b0;
    end else begin
      if (erase_write) begin
        reset_blocked    <= 1'b1;
        soft_reset_req_o <= 1'b0;
      end else if (dbg_wr && lreq_sync.addr == dcap_pkg::DBG_SOFT_RESET_REQUEST
                   && !reset_blocked) begin
        soft_reset_req_o <= lreq_sync.wdata[dcap_pkg::CTRL_BIT];
      end
      if (soft_reset_req_o) begin
        reset_cause_soft_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mailboxes
  logic [31:0] d2c_word;
  logic [31:0] c2d_word;
  logic        d2c_recv;
  logic        d2c_send;
  logic        c2d_recv;
  logic        c2d_send;
  logic        d2c_take;
  logic        c2d_take;
  logic        d2c_put;
  logic        c2d_put;
  logic        d2c_took;
  logic        c2d_took;

  assign d2c_put  = dbg_wr && lreq_sync.addr == dcap_pkg::DBG_MBOX_SEND_WORD;
  assign c2d_put  = cpu_wr && cpu_req_i.addr == dcap_pkg::CPU_MBOX_SEND_WORD;
  assign d2c_take = cpu_rd && cpu_req_i.addr == dcap_pkg::CPU_MBOX_RECV_WORD;
  assign c2d_take = dbg_rd && lreq_sync.addr == dcap_pkg::DBG_MBOX_RECV_WORD;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      d2c_word <= dcap_pkg::WORD_ZERO;
      c2d_word <= dcap_pkg::WORD_ZERO;
    end else begin
      if (d2c_put) begin
        d2c_word <= lreq_sync.wdata;
      end
      if (c2d_put) begin
        c2d_word <= cpu_req_i.wdata;
      end
    end
  end

  // Flags, receive first; a send wins over a clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      d2c_recv <= dcap_pkg::WORD_TAKEN;
      d2c_send <= dcap_pkg::WORD_TAKEN;
      c2d_recv <= dcap_pkg::WORD_TAKEN;
      c2d_send <= dcap_pkg::WORD_TAKEN;
      d2c_took <= 1'b0;
      c2d_took <= 1'b0;
    end else begin
      d2c_took <= d2c_take & ~d2c_put;
      c2d_took <= c2d_take & ~c2d_put;
      if (d2c_put) begin
        d2c_recv <= dcap_pkg::WORD_WAITING;
        d2c_send <= dcap_pkg::WORD_WAITING;
      end else begin
        if (d2c_take) begin
          d2c_recv <= dcap_pkg::WORD_TAKEN;
        end
        if (d2c_took) begin
          d2c_send <= dcap_pkg::WORD_TAKEN;
        end
      end
      if (c2d_put) begin
        c2d_recv <= dcap_pkg::WORD_WAITING;
        c2d_send <= dcap_pkg::WORD_WAITING;
      end else begin
        if (c2d_take) begin
          c2d_recv <= dcap_pkg::WORD_TAKEN;
        end
        if (c2d_took) begin
          c2d_send <= dcap_pkg::WORD_TAKEN;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Debugger read answers
  logic [31:0] next_link_rdata;

  always_comb begin
    next_link_rdata = dcap_pkg::WORD_ZERO;
    case (lreq_sync.addr)
      dcap_pkg::DBG_SOFT_RESET_REQUEST: next_link_rdata[dcap_pkg::CTRL_BIT] = soft_reset_req_o;
      dcap_pkg::DBG_ERASE_ALL_PROGRESS: next_link_rdata[dcap_pkg::CTRL_BIT] =
        state != dcap_pkg::DCAP_ES_IDLE && state != dcap_pkg::DCAP_ES_DONE;
      dcap_pkg::DBG_ACCESS_GUARD_STATE: begin
        next_link_rdata[dcap_pkg::CTRL_BIT]         = access_guard;
        next_link_rdata[dcap_pkg::SECURE_GUARD_BIT] = secure_guard;
      end
      dcap_pkg::DBG_ERASE_GUARD_STATE:  next_link_rdata[dcap_pkg::CTRL_BIT] = erase_guard;
      dcap_pkg::DBG_MBOX_SEND_FLAG:     next_link_rdata[dcap_pkg::CTRL_BIT] = d2c_send;
      dcap_pkg::DBG_MBOX_RECV_WORD:     next_link_rdata = c2d_word;
      dcap_pkg::DBG_MBOX_RECV_FLAG:     next_link_rdata[dcap_pkg::CTRL_BIT] = c2d_recv;
      dcap_pkg::DBG_PORT_IDENT:         next_link_rdata = PORT_IDENT;
      default:                          next_link_rdata = dcap_pkg::WORD_ZERO;
    endcase
  end

  // Ack toggles so the debug port can pick it up on its own clock
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      link_rdata_o <= dcap_pkg::WORD_ZERO;
      link_ack_o   <= 1'b0;
    end else if (link_stb) begin
      link_ack_o <= ~link_ack_o;
      if (!lreq_sync.wr) begin
        link_rdata_o <= next_link_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU read answers
  logic [31:0] next_cpu_rdata;

  always_comb begin
    next_cpu_rdata = dcap_pkg::WORD_ZERO;
    case (cpu_req_i.addr)
      dcap_pkg::CPU_MBOX_RECV_WORD:   next_cpu_rdata = d2c_word;
      dcap_pkg::CPU_MBOX_RECV_FLAG:   next_cpu_rdata[dcap_pkg::CTRL_BIT] = d2c_recv;
      dcap_pkg::CPU_MBOX_SEND_FLAG:   next_cpu_rdata[dcap_pkg::CTRL_BIT] = c2d_send;
      dcap_pkg::CPU_ERASE_GUARD_LOCK: next_cpu_rdata[dcap_pkg::CTRL_BIT] = key_lock;
      default:                        next_cpu_rdata = dcap_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_rdata_o <= dcap_pkg::WORD_ZERO;
      cpu_ready_o <= 1'b0;
    end else begin
      cpu_ready_o <= cpu_req_i.sel;
      if (cpu_rd) begin
        cpu_rdata_o <= next_cpu_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_ERASE_REFUSED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state == dcap_pkg::DCAP_ES_IDLE && erase_write && erase_guard && !key_match)
      |=> state == dcap_pkg::DCAP_ES_IDLE)
    else $error("erase-all accepted under erase guard");

  AST_ERASE_START: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state == dcap_pkg::DCAP_ES_IDLE && erase_start)
      |=> state == dcap_pkg::DCAP_ES_FLASH ##1 erase_req_o)
    else $error("erase did not start with flash");

  AST_BUSY_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (dbg_rd && lreq_sync.addr == dcap_pkg::DBG_ERASE_ALL_PROGRESS
     && state inside {dcap_pkg::DCAP_ES_FLASH, dcap_pkg::DCAP_ES_SRAM, dcap_pkg::DCAP_ES_USER_CFG,
                      dcap_pkg::DCAP_ES_PERIPH, dcap_pkg::DCAP_ES_SUB_DOMAIN})
      |=> link_rdata_o[dcap_pkg::CTRL_BIT])
    else $error("progress not busy mid erase");

  AST_SUB_LAST: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == dcap_pkg::DCAP_ES_SUB_DOMAIN |-> $past(state) inside
      {dcap_pkg::DCAP_ES_PERIPH, dcap_pkg::DCAP_ES_SUB_DOMAIN})
    else $error("subordinate erased before application");

  AST_RESET_KILL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    erase_write |=> !soft_reset_req_o [*8])
    else $error("reset request survived erase write");

  AST_KEY_LOCK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    key_lock |=> key_lock && $stable(cpu_key) || cpu_key == dcap_pkg::WORD_ZERO)
    else $error("key changed while locked");

  AST_MBOX_ORDER: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    // A fresh send right after the read may legally leave both flags waiting
    (d2c_take && !d2c_put && d2c_send) |=> !d2c_recv && d2c_send ##1 (!d2c_send || d2c_recv))
    else $error("mailbox flags cleared out of order");

  AST_MBOX_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    c2d_put |=> c2d_recv && c2d_send && c2d_word == $past(cpu_req_i.wdata))
    else $error("send did not mark word waiting");

  AST_AP_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cfg_taken && access_guard) |=> !processor_ap_enable_o && !dbg_flash_write_allow_o)
    else $error("processor port open under access guard");

  AST_KEY_ERASE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (key_match && state == dcap_pkg::DCAP_ES_IDLE) |=> state == dcap_pkg::DCAP_ES_FLASH)
    else $error("matching keys did not start erase");

endmodule
`default_nettype wire

// [logic/dcap_pkg.sv]
/*
 * Shared constants and carriers for the debug control access port.
 * Assumes one system clock; debugger-side accesses arrive from the debug
 * port logic on the link clock and are resampled inside the port.
 */
`default_nettype none
package dcap_pkg;

  // Debugger-side register offsets (link side only)
  localparam logic [7:0] DBG_SOFT_RESET_REQUEST = 8'h00;
  localparam logic [7:0] DBG_ERASE_ALL_TRIGGER  = 8'h04;
  localparam logic [7:0] DBG_ERASE_ALL_PROGRESS = 8'h08;
  localparam logic [7:0] DBG_ACCESS_GUARD_STATE = 8'h0c;
  localparam logic [7:0] DBG_ERASE_GUARD_STATE  = 8'h18;
  localparam logic [7:0] DBG_ERASE_GUARD_KEY    = 8'h1c;
  localparam logic [7:0] DBG_MBOX_SEND_WORD     = 8'h20;
  localparam logic [7:0] DBG_MBOX_SEND_FLAG     = 8'h24;
  localparam logic [7:0] DBG_MBOX_RECV_WORD     = 8'h28;
  localparam logic [7:0] DBG_MBOX_RECV_FLAG     = 8'h2c;
  localparam logic [7:0] DBG_PORT_IDENT         = 8'hfc;

  // CPU-side register offsets
  localparam logic [11:0] CPU_MBOX_RECV_WORD    = 12'h400;
  localparam logic [11:0] CPU_MBOX_RECV_FLAG    = 12'h404;
  localparam logic [11:0] CPU_MBOX_SEND_WORD    = 12'h480;
  localparam logic [11:0] CPU_MBOX_SEND_FLAG    = 12'h484;
  localparam logic [11:0] CPU_ERASE_GUARD_LOCK  = 12'h500;
  localparam logic [11:0] CPU_ERASE_GUARD_KEY   = 12'h504;

  // Field positions and values
  localparam int          CTRL_BIT              = 0;
  localparam int          SECURE_GUARD_BIT      = 1;
  localparam logic [31:0] WORD_ZERO             = 32'h0000_0000;
  localparam logic        WORD_WAITING          = 1'b1;
  localparam logic        WORD_TAKEN            = 1'b0;

  // Port identification value; arbitrary, chosen for this block only
  localparam logic [31:0] PORT_IDENT_DEFAULT    = 32'h1234_5670;

  typedef enum logic [2:0] {
    DCAP_ES_IDLE,
    DCAP_ES_FLASH,
    DCAP_ES_SRAM,
    DCAP_ES_USER_CFG,
    DCAP_ES_PERIPH,
    DCAP_ES_SUB_DOMAIN,
    DCAP_ES_DONE
  } dcap_erase_state_type;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dcap_link_req_type;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dcap_cpu_req_type;

endpackage
`default_nettype wire

// [dv/dcap_dbg_model.sv]
/*
 * Debugger model: drives the debug port's parallel request and link clock.
 * Assumes the port resamples both and toggles link_ack_i once per access.
 */
`timescale 1ns/1ps
`default_nettype none
module dcap_dbg_model (
  input  wire logic                    clk_i,
  input  wire logic                    link_ack_i,
  input  wire logic [31:0]             link_rdata_i,
  output var  logic                    link_clk_o,
  output var  dcap_pkg::dcap_link_req_type link_req_o
);
  initial begin
    link_clk_o = 1'b0;
    link_req_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock stands still between frames; released lines show inverted data
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    logic ack0;
    ack0 = link_ack_i;
    @(posedge clk_i);
    link_req_o <= '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
    repeat (4) @(posedge clk_i);
    link_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    link_clk_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdata = link_rdata_i;
    ok    = (link_ack_i !== ack0);
    link_req_o <= '{req: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
/*
 * Self-checking bench for the debug control access port.
 * Assumes the debugger model above and a tb-driven erase engine and CPU bus.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ag = 1'b1;
  logic sag = 1'b0;
  logic eg = 1'b1;
  logic sub = 1'b0;
  logic edone = 1'b0;
  logic link_clk, ack, rdy, ereq, grel, srst, rcause, apen, fwa;
  logic [31:0] lrd, crd, rd;
  dcap_pkg::dcap_link_req_type    lreq;
  dcap_pkg::dcap_cpu_req_type     creq = '0;
  dcap_pkg::dcap_erase_state_type stg;
  int err_total = 0;
  int n_checks = 0;

  always #12.5 clk_i = ~clk_i;

  dcap_ctrl_port u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk),
    .link_req_i(lreq), .link_rdata_o(lrd), .link_ack_o(ack), .cpu_req_i(creq),
    .cpu_rdata_o(crd), .cpu_ready_o(rdy), .access_guard_i(ag), .secure_access_guard_i(sag),
    .erase_guard_i(eg), .sub_domain_erase_i(sub), .erase_done_i(edone), .erase_req_o(ereq),
    .erase_stage_o(stg), .guard_release_o(grel), .soft_reset_req_o(srst),
    .reset_cause_soft_o(rcause), .processor_ap_enable_o(apen),
    .dbg_flash_write_allow_o(fwa));
  dcap_dbg_model u_dbg (.clk_i(clk_i), .link_ack_i(ack), .link_rdata_i(lrd),
    .link_clk_o(link_clk), .link_req_o(lreq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic dbg(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    u_dbg.access(wr, a, d, rd, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic cpu(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    creq <= '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    @(posedge clk_i);
    creq <= '{sel: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
    @(posedge clk_i);
    // Ready stands one cycle only: sample it at the edge that ends it
    chk({31'h0, rdy}, 32'h1);
    rd = crd;
  endtask
  task automatic rst(input logic a, input logic e, input logic s);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    ag <= a;
    eg <= e;
    sub <= s;
    sag <= s;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Plays the erase engine, ending each stage with one done pulse
  task automatic run_erase(input logic s);
    int i;
    for (i = 0; i < 20 && ereq !== 1'b1; i++) @(posedge clk_i);
    chk({31'h0, ereq}, 32'h1);
    for (i = 1; i <= (s ? 5 : 4); i++) begin
      chk({29'h0, stg}, i);
      @(posedge clk_i);
      edone <= 1'b1;
      @(posedge clk_i);
      edone <= 1'b0;
      @(posedge clk_i);
      #1;
    end
    chk({29'h0, stg}, {29'h0, dcap_pkg::DCAP_ES_DONE});
    chk({30'h0, grel, ereq}, 32'h2);
  endtask
  task automatic tdone(input string s);
    $display("test %s done, mismatches %0d", s, err_total);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end

  initial begin
    rst(1'b1, 1'b1, 1'b0);
    dbg(0, 8'hfc, 0); chk(rd, dcap_pkg::PORT_IDENT_DEFAULT);
    dbg(0, 8'h40, 0); chk(rd, 32'h0);
    cpu(0, 12'h0fc, 0); chk(rd, 32'h0);
    dbg(0, 8'h0c, 0); chk(rd, 32'h1);
    dbg(0, 8'h18, 0); chk(rd, 32'h1);
    chk({30'h0, apen, fwa}, 32'h0);
    dbg(1, 8'h04, 1); dbg(0, 8'h08, 0); chk({rd[30:0], ereq}, 32'h0);
    tdone("guards");
    dbg(1, 8'h20, 32'ha5a5_0001); dbg(1, 8'h20, 32'h5a5a_0002);
    dbg(0, 8'h24, 0); chk(rd, 32'h1);
    cpu(0, 12'h404, 0); chk(rd, 32'h1);
    cpu(0, 12'h400, 0); chk(rd, 32'h5a5a_0002);
    cpu(0, 12'h404, 0); chk(rd, 32'h0);
    dbg(0, 8'h24, 0); chk(rd, 32'h0);
    cpu(1, 12'h480, 32'hc0de_0003); cpu(0, 12'h484, 0); chk(rd, 32'h1);
    dbg(0, 8'h2c, 0); chk(rd, 32'h1);
    dbg(0, 8'h28, 0); chk(rd, 32'hc0de_0003);
    dbg(0, 8'h2c, 0); chk(rd, 32'h0);
    cpu(0, 12'h484, 0); chk(rd, 32'h0);
    tdone("mailbox");
    cpu(1, 12'h500, 32'h1);
    cpu(1, 12'h500, 32'h0); cpu(0, 12'h500, 0); chk(rd, 32'h1);
    cpu(1, 12'h504, 32'h0bad_f00d); dbg(1, 8'h1c, 32'h0bad_f00d);
    repeat (4) @(posedge clk_i);
    chk({31'h0, ereq}, 0);
    tdone("lock");
    rst(1'b0, 1'b0, 1'b1);
    chk({30'h0, apen, fwa}, 32'h3);
    dbg(0, 8'h0c, 0); chk(rd, 32'h2);
    dbg(1, 8'h00, 1); chk({30'h0, srst, rcause}, 32'h3);
    dbg(1, 8'h04, 1); chk({31'h0, srst}, 32'h0);
    dbg(1, 8'h00, 1); chk({31'h0, srst}, 32'h0);
    dbg(0, 8'h08, 0); chk(rd, 32'h1);
    run_erase(1'b1);
    tdone("erase");
    rst(1'b1, 1'b1, 1'b0);
    cpu(1, 12'h504, 32'h1357_9bdf); dbg(1, 8'h1c, 32'h1357_9bdf);
    run_erase(1'b0);
    tdone("keys");
    report_and_stop();
  end
endmodule
`default_nettype wire
